/* File: design/usart_rx_pkg.sv */
/*
  Constants and carrier types for the synchronous master receive path.
  Assumes a single clock domain (mclk) and a plain strobe register port.
*/
package usart_rx_pkg;
  // Register indices on the plain port
  localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_RECEIVE_FIFO   = 2'h1;
  localparam logic [1:0] ADDR_BAUD_DIVISOR   = 2'h2;
  localparam logic [1:0] ADDR_MODE_CONTROL   = 2'h3;
  // Status/control bit positions
  localparam int BIT_SERIAL_PORT_ON = 7;
  localparam int BIT_NINTH_ENABLE   = 6;
  localparam int BIT_SINGLE_ENABLE  = 5;
  localparam int BIT_CONT_ENABLE    = 4;
  localparam int BIT_FRAMING_ERROR  = 2;
  localparam int BIT_OVERRUN        = 1;
  localparam int BIT_NINTH_DATA     = 0;
  // Mode control bit positions
  localparam int BIT_SYNC_MODE      = 0;
  localparam int BIT_CLOCK_MASTER   = 1;
  localparam int BIT_IRQ_ENABLE     = 2;
  localparam int BIT_RECEIVE_FLAG   = 7;
  // Reset values and widths
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam int DATA_BITS  = 8;
  localparam int FIFO_DEPTH = 2;
  // One FIFO entry: data plus per-word status
  typedef struct packed {
    logic       ninth;
    logic       framing;
    logic [7:0] data;
  } rx_entry_t;
  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW, ST_DONE} rx_state_t;
endpackage : usart_rx_pkg

/* File: design/usart_sync_master_receiver.sv */
/*
  Receive path of a USART in synchronous master mode: clock generation from
  the baud divisor, falling-edge sampling, shift register, two-entry FIFO
  with per-entry status, overrun handling and receive flag.
  Assumes the serial data line is synchronous to mclk and software keeps
  the documented setup order and reads status before popping data.
*/
`timescale 1ns/1ns
module usart_sync_master_receiver #(
  parameter int DATA_W = usart_rx_pkg::DATA_BITS
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial link
  input  wire logic       serial_data_line,
  output logic            serial_clock_out,
  output logic            serial_clock_oe,
  // Interrupt request
  output logic            receive_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [7:0]  baud_divisor_ff;
  logic        serial_port_on_ff, ninth_bit_receive_enable_ff;
  logic        single_receive_enable_ff, continuous_receive_enable_ff;
  logic        sync_mode_ff, clock_master_select_ff, receive_irq_enable_ff;
  logic        overrun_error_flag_ff;
  logic        word_done;
  logic        fifo_full;
  logic        fifo_pop;
  logic        rx_active;

  wire wr_stat = reg_wr && reg_addr == usart_rx_pkg::ADDR_STATUS_CONTROL;
  wire wr_mode = reg_wr && reg_addr == usart_rx_pkg::ADDR_MODE_CONTROL;

  // Software-written control bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_port_on_ff            <= 1'b0;
      ninth_bit_receive_enable_ff  <= 1'b0;
      continuous_receive_enable_ff <= 1'b0;
      sync_mode_ff                 <= 1'b0;
      clock_master_select_ff       <= 1'b0;
      receive_irq_enable_ff        <= 1'b0;
      baud_divisor_ff              <= usart_rx_pkg::BAUD_RESET;
    end else begin
      if (wr_stat) begin
        serial_port_on_ff            <= reg_wdata[usart_rx_pkg::BIT_SERIAL_PORT_ON];
        ninth_bit_receive_enable_ff  <= reg_wdata[usart_rx_pkg::BIT_NINTH_ENABLE];
        continuous_receive_enable_ff <= reg_wdata[usart_rx_pkg::BIT_CONT_ENABLE];
      end
      if (wr_mode) begin
        sync_mode_ff           <= reg_wdata[usart_rx_pkg::BIT_SYNC_MODE];
        clock_master_select_ff <= reg_wdata[usart_rx_pkg::BIT_CLOCK_MASTER];
        receive_irq_enable_ff  <= reg_wdata[usart_rx_pkg::BIT_IRQ_ENABLE];
      end
      if (reg_wr && reg_addr == usart_rx_pkg::ADDR_BAUD_DIVISOR)
        baud_divisor_ff <= reg_wdata;
    end
  end

  // Single enable: written by software, dropped by hardware after one word unless continuous enable is set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      single_receive_enable_ff <= 1'b0;
    end else if (wr_stat) begin
      single_receive_enable_ff <= reg_wdata[usart_rx_pkg::BIT_SINGLE_ENABLE];
    end else if (word_done && !continuous_receive_enable_ff) begin
      single_receive_enable_ff <= 1'b0;
    end
  end

  // Overrun: set on full FIFO at last bit, cleared with continuous enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (word_done && fifo_full && !overrun_error_flag_ff) begin
      overrun_error_flag_ff <= 1'b1;
    end else if (!continuous_receive_enable_ff || !serial_port_on_ff) begin
      overrun_error_flag_ff <= 1'b0;
    end
  end

  // Reception runs in sync master mode with either enable, no overrun
  assign rx_active = serial_port_on_ff && sync_mode_ff && clock_master_select_ff &&
                     (single_receive_enable_ff || continuous_receive_enable_ff) &&
                     !overrun_error_flag_ff;

  ////////////////////////////////////////////////////////////////////////
  // Baud generator and receive state machine
  usart_rx_pkg::rx_state_t state_ff;
  logic [7:0]  baud_cnt_ff;
  logic [3:0]  bit_cnt_ff;
  logic [8:0]  shift_ff;
  logic        sclk_ff;
  wire         baud_tick = baud_cnt_ff == 8'h00;
  wire  [3:0]  last_bit = ninth_bit_receive_enable_ff ? 4'(DATA_W) : 4'(DATA_W - 1);

  // Divisor reload: each half serial period is divisor+1 mclk cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_ff <= usart_rx_pkg::BAUD_RESET;
    end else if (!rx_active || baud_tick) begin
      baud_cnt_ff <= baud_divisor_ff;
    end else begin
      baud_cnt_ff <= baud_cnt_ff - 8'h01;
    end
  end

  // Clock phases; a falling edge samples the line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= usart_rx_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 9'h000;
      sclk_ff    <= 1'b0;
    end else if (!rx_active) begin
      state_ff   <= usart_rx_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      sclk_ff    <= 1'b0;
    end else begin
      case (state_ff)
        usart_rx_pkg::ST_IDLE: begin
          bit_cnt_ff <= 4'h0;
          if (baud_tick) begin
            state_ff <= usart_rx_pkg::ST_HIGH;
            sclk_ff  <= 1'b1;
          end
        end
        usart_rx_pkg::ST_HIGH: begin
          if (baud_tick) begin
            sclk_ff  <= 1'b0;
            shift_ff[bit_cnt_ff] <= serial_data_line;
            state_ff <= (bit_cnt_ff == last_bit) ? usart_rx_pkg::ST_DONE
                                                 : usart_rx_pkg::ST_LOW;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        usart_rx_pkg::ST_LOW: begin
          if (baud_tick) begin
            sclk_ff  <= 1'b1;
            state_ff <= usart_rx_pkg::ST_HIGH;
          end
        end
        usart_rx_pkg::ST_DONE: begin
          bit_cnt_ff <= 4'h0;
          state_ff   <= usart_rx_pkg::ST_LOW; // back to back
        end
        default: state_ff <= usart_rx_pkg::ST_IDLE;
      endcase
    end
  end

  assign word_done = rx_active && state_ff == usart_rx_pkg::ST_DONE;

  ////////////////////////////////////////////////////////////////////////
  // Two-entry FIFO with per-entry status
  usart_rx_pkg::rx_entry_t fifo_mem [usart_rx_pkg::FIFO_DEPTH];
  logic        wr_ptr_ff, rd_ptr_ff;
  logic [1:0]  count_ff;
  wire         fifo_push = word_done && !fifo_full && !overrun_error_flag_ff;
  assign fifo_full = count_ff == 2'(usart_rx_pkg::FIFO_DEPTH);
  assign fifo_pop  = reg_rd && reg_addr == usart_rx_pkg::ADDR_RECEIVE_FIFO && count_ff != 2'h0;

  // Pointer and count; read advances status to next entry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (fifo_push) wr_ptr_ff <= ~wr_ptr_ff;
      if (fifo_pop)  rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  // Entry storage: data, ninth bit, framing error (always clear in sync mode)
  always_ff @(posedge mclk) begin
    if (fifo_push)
      fifo_mem[wr_ptr_ff] <= '{ninth: ninth_bit_receive_enable_ff && shift_ff[DATA_W],
                                framing: 1'b0, data: shift_ff[7:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, flag and pins
  usart_rx_pkg::rx_entry_t head;
  logic receive_flag;
  assign head = (count_ff != 2'h0) ? fifo_mem[rd_ptr_ff] : '0;
  assign receive_flag = count_ff != 2'h0; // set on push, clear when empty

  // Read data appear one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        usart_rx_pkg::ADDR_STATUS_CONTROL:
          reg_rdata <= {serial_port_on_ff, ninth_bit_receive_enable_ff,
                        single_receive_enable_ff, continuous_receive_enable_ff, 1'b0,
                        head.framing, overrun_error_flag_ff, head.ninth};
        usart_rx_pkg::ADDR_RECEIVE_FIFO:   reg_rdata <= head.data;
        usart_rx_pkg::ADDR_BAUD_DIVISOR:   reg_rdata <= baud_divisor_ff;
        usart_rx_pkg::ADDR_MODE_CONTROL:
          reg_rdata <= {receive_flag, 4'h0, receive_irq_enable_ff,
                        clock_master_select_ff, sync_mode_ff};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Registered pin and interrupt outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_clock_out <= 1'b0;
      serial_clock_oe  <= 1'b0;
      receive_irq      <= 1'b0;
    end else begin
      serial_clock_out <= sclk_ff;
      serial_clock_oe  <= serial_port_on_ff && sync_mode_ff && clock_master_select_ff;
      receive_irq      <= receive_flag && receive_irq_enable_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Steps of a transfer, used by the checks below
  // Falling edge of the serial clock while a word is in flight
  sequence s_fall_edge;
    rx_active && state_ff == usart_rx_pkg::ST_HIGH && baud_tick;
  endsequence
  // Last falling edge of a word
  sequence s_last_fall;
    rx_active && state_ff == usart_rx_pkg::ST_HIGH && baud_tick && bit_cnt_ff == last_bit;
  endsequence
  // End of a single-mode word with no status write beside it
  sequence s_single_end;
    word_done && !continuous_receive_enable_ff && !wr_stat ##1 !wr_stat;
  endsequence
  // Serial clock held low for three cycles
  sequence s_clock_quiet;
    !sclk_ff [*3];
  endsequence
  // A push into an empty FIFO
  sequence s_push_empty;
    fifo_push && count_ff == 2'h0;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Overrun holds the shifter out of the FIFO
  a_overrun_blocks_push: assert property (@(posedge mclk) disable iff (!rst_n)
    overrun_error_flag_ff |-> !fifo_push) else $error("push during overrun");
  // Word end on a full FIFO raises overrun
  a_full_sets_overrun: assert property (@(posedge mclk) disable iff (!rst_n)
    word_done && fifo_full |=> overrun_error_flag_ff) else $error("overrun missed");
  // Push shows the flag next cycle and the gated request one later
  a_push_raises_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    fifo_push |=> receive_flag ##1 (receive_irq == $past(receive_irq_enable_ff)))
    else $error("flag or irq wrong after push");
  // Popping the last entry clears the flag
  a_flag_clears_empty: assert property (@(posedge mclk) disable iff (!rst_n)
    count_ff == 2'h1 && fifo_pop && !fifo_push |=> !receive_flag)
    else $error("flag stuck after empty");
  // Dropping continuous enable clears overrun
  a_continuous_receive_enable_clears_ovr: assert property (@(posedge mclk) disable iff (!rst_n)
    !continuous_receive_enable_ff && !(word_done && fifo_full) |=> !overrun_error_flag_ff)
    else $error("overrun not cleared");
  // Single mode drops its enable after one word
  a_single_stops: assert property (@(posedge mclk) disable iff (!rst_n)
    word_done && !continuous_receive_enable_ff && !wr_stat |=> !single_receive_enable_ff)
    else $error("single receive did not stop");
  // No clock pulses while inactive
  a_idle_no_clock: assert property (@(posedge mclk) disable iff (!rst_n)
    !rx_active |=> !sclk_ff) else $error("clock while idle");
  // Never more than two stored entries
  a_fifo_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    count_ff <= 2'(usart_rx_pkg::FIFO_DEPTH)) else $error("fifo overfilled");
  // Continuous mode keeps running after a stored word
  a_cont_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
    word_done && continuous_receive_enable_ff && !fifo_full |=> rx_active || wr_stat || $past(wr_stat))
    else $error("continuous stopped");
  // The line is taken on the falling edge, into the counted bit
  a_fall_samples: assert property (@(posedge mclk) disable iff (!rst_n)
    s_fall_edge |=> !sclk_ff && shift_ff[$past(bit_cnt_ff)] == $past(serial_data_line))
    else $error("bit not sampled on falling edge");
  // Word length follows the ninth-bit enable
  a_last_bit_done: assert property (@(posedge mclk) disable iff (!rst_n)
    s_last_fall |=> state_ff == usart_rx_pkg::ST_DONE)
    else $error("word length wrong");
  // Each half period reloads from the divisor
  a_half_period: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_active && baud_tick |=> baud_cnt_ff == $past(baud_divisor_ff))
    else $error("baud reload wrong");
  // Dropping the enables returns the receiver to idle
  a_drop_idles: assert property (@(posedge mclk) disable iff (!rst_n)
    !rx_active |=> state_ff == usart_rx_pkg::ST_IDLE && bit_cnt_ff == 4'h0)
    else $error("receiver not reset");
  // After a single word the clock stays quiet
  a_single_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    s_single_end |-> s_clock_quiet)
    else $error("clock after single word");
  // Entry keeps the word and its ninth bit
  a_entry_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    s_push_empty |=> head.data == $past(shift_ff[7:0]) &&
                     head.ninth == $past(ninth_bit_receive_enable_ff && shift_ff[DATA_W]))
    else $error("entry lost data or status");
  // Request only follows an enabled flag
  a_irq_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    receive_irq |-> $past(receive_irq_enable_ff) && $past(receive_flag))
    else $error("request without enable");
  // A pop alone drops one entry
  a_pop_advances: assert property (@(posedge mclk) disable iff (!rst_n)
    fifo_pop && !fifo_push |=> count_ff == $past(count_ff) - 2'h1)
    else $error("pop did not advance");
  // Read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule : usart_sync_master_receiver

/* File: sim/sync_slave_model.sv */
/*
  Serial slave that feeds words onto the data line, LSB first.
  Assumes the serial clock and its enable come from the receiver.
*/
`timescale 1ns/1ns
module sync_slave_model (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // Serial link
  input  wire logic            sclk,
  input  wire logic            oe,
  output logic                 data,
  // Word source
  input  wire logic            nine,
  input  wire logic [3:0][8:0] words,
  output logic      [7:0]      done_cnt
);
  logic       sclk_ff;
  logic [3:0] bit_ff;
  logic       idle_ff;
  // New bit on each rise; line toggles while idle so stale data never matches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_ff  <= 1'b0;
      bit_ff   <= 4'h0;
      idle_ff  <= 1'b1;
      data     <= 1'b0;
      done_cnt <= 8'h00;
    end else begin
      sclk_ff <= sclk;
      if (!oe) begin
        bit_ff   <= 4'h0;
        done_cnt <= 8'h00;
        idle_ff  <= 1'b1;
        data     <= ~data;
      end else if (sclk && !sclk_ff) begin
        data    <= words[done_cnt[1:0]][bit_ff];
        idle_ff <= 1'b0;
      end else if (!sclk && sclk_ff) begin
        if (bit_ff == (nine ? 4'h8 : 4'h7)) begin
          bit_ff   <= 4'h0;
          done_cnt <= done_cnt + 8'h01;
          idle_ff  <= 1'b1;
        end else begin
          bit_ff <= bit_ff + 4'h1;
        end
      end else if (idle_ff) begin
        data <= ~data;
      end
    end
  end
endmodule : sync_slave_model

/* File: sim/usart_sync_master_receiver_test.sv */
/*
  Self-checking bench for the synchronous master receive path.
  Assumes the slave model in sync_slave_model.sv and a 25 MHz mclk.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module usart_sync_master_receiver_test;
  logic mclk, rst_n, reg_wr, reg_rd, sdl, sclk, oe, irq, nine;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, done_cnt;
  logic [3:0][8:0] words;
  int mismatches, n_compared, cyc;
  usart_sync_master_receiver dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_data_line(sdl), .serial_clock_out(sclk), .serial_clock_oe(oe),
    .receive_irq(irq));
  sync_slave_model slave_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .oe(oe),
    .data(sdl), .nine(nine), .words(words), .done_cnt(done_cnt));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_words(input logic [7:0] n);
    int k;
    for (k = 0; k < 3000 && done_cnt < n; k++) @(posedge mclk);
    if (done_cnt < n) mismatches++;
    repeat (6) @(posedge mclk);
  endtask : wait_words
  // Enables cleared first, then divisor, then mode bits, then enable
  task automatic setup(input logic [7:0] mode, input logic [7:0] stat);
    wr(usart_rx_pkg::ADDR_STATUS_CONTROL, 8'h00);
    wr(usart_rx_pkg::ADDR_BAUD_DIVISOR, 8'h03);
    wr(usart_rx_pkg::ADDR_MODE_CONTROL, mode);
    wr(usart_rx_pkg::ADDR_STATUS_CONTROL, stat);
  endtask : setup
  ////////////////////////////////////////////////////////////////////////////
  // Single word, clock rate, flag and request
  task automatic single_word;
    logic [7:0] d;
    int hi;
    nine <= 1'b0;
    setup(8'h07, 8'ha0);
    @(posedge sclk);
    @(negedge mclk);
    for (hi = 0; sclk && hi < 50; hi++) @(negedge mclk);
    `CHK(hi, 4)
    wait_words(8'h01);
    `CHK(irq, 1'b1)
    rd(usart_rx_pkg::ADDR_MODE_CONTROL, d);
    `CHK(d, 8'h87)
    rd(usart_rx_pkg::ADDR_RECEIVE_FIFO, d);
    `CHK(d, 8'ha5)
    repeat (60) @(posedge mclk);
    `CHK(done_cnt, 8'h01)
    `CHK(sclk, 1'b0)
    `CHK(irq, 1'b0)
    wr(usart_rx_pkg::ADDR_MODE_CONTROL, 8'h87);
    rd(usart_rx_pkg::ADDR_MODE_CONTROL, d);
    `CHK(d, 8'h07)
  endtask : single_word
  // Both enables, ninth bit, overrun and its release
  task automatic overrun_run;
    logic [7:0] d;
    nine <= 1'b1;
    setup(8'h07, 8'hf0);
    wait_words(8'h03);
    repeat (120) @(posedge mclk);
    `CHK(done_cnt, 8'h03)
    wr(usart_rx_pkg::ADDR_MODE_CONTROL, 8'h03);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    rd(usart_rx_pkg::ADDR_STATUS_CONTROL, d);
    `CHK(d[2:0], 3'h3)
    rd(usart_rx_pkg::ADDR_RECEIVE_FIFO, d);
    `CHK(d, 8'ha5)
    rd(usart_rx_pkg::ADDR_STATUS_CONTROL, d);
    `CHK(d[2:0], 3'h2)
    rd(usart_rx_pkg::ADDR_RECEIVE_FIFO, d);
    `CHK(d, 8'h3c)
    wr(usart_rx_pkg::ADDR_STATUS_CONTROL, 8'hc0);
    rd(usart_rx_pkg::ADDR_STATUS_CONTROL, d);
    `CHK(d[2:0], 3'h0)
    rd(usart_rx_pkg::ADDR_RECEIVE_FIFO, d);
    `CHK(d, 8'h00)
  endtask : overrun_run
  // Abort in mid-word, then a clean word after re-enable
  task automatic abort_word;
    logic [7:0] d;
    nine <= 1'b0;
    setup(8'h03, 8'ha0);
    repeat (30) @(posedge mclk);
    wr(usart_rx_pkg::ADDR_STATUS_CONTROL, 8'h00);
    repeat (20) @(posedge mclk);
    `CHK(sclk, 1'b0)
    `CHK(oe, 1'b0)
    rd(usart_rx_pkg::ADDR_MODE_CONTROL, d);
    `CHK(d, 8'h03)
    wr(usart_rx_pkg::ADDR_STATUS_CONTROL, 8'ha0);
    wait_words(8'h01);
    rd(usart_rx_pkg::ADDR_RECEIVE_FIFO, d);
    `CHK(d, 8'ha5)
  endtask : abort_word
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 2'h0; reg_wdata = 8'h00;
    nine = 1'b0; mismatches = 0; n_compared = 0; cyc = 0;
    words = {9'h0c3, 9'h1ff, 9'h03c, 9'h1a5};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    single_word();
    overrun_run();
    abort_word();
    give_verdict();
  end
endmodule : usart_sync_master_receiver_test
